// File: hdl/t01_regs.svh
// Behaviour
// - only timer 1 overflows feed the UART baud tick, never timer 0
// - mode 2 counts only when run bit and gate/pin permit, as modes 0 and 1
// - timer 1 in mode 3 holds its count and stops
// - timer 0 in mode 3 splits into two independent 8-bit counters
// - split low byte uses timer 0 select, gate, run, pin 0 and flag 0
// - select bit 2 set: split low byte counts falling edges of count pin 0
// - split high byte counts clocks, runs on run bit 1, sets flag 1
// - timer 0 in mode 3: timer 1 runs unless its own mode is 3 or its gate/pin blocks it
// - timer 0 in mode 3: timer 1 still works in modes 0, 1 and 2
// - timer 0 in mode 3: timer 1 ignores run bit 1, never sets flag 1
// - timer 0 in mode 3: timer 1 overflows still tick baud, no interrupt
`ifndef T01_REGS_SVH
`define T01_REGS_SVH
`define T01_OFS_MODE 8'h00
`define T01_OFS_CTRL 8'h04
`define T01_OFS_CNT0 8'h08
`define T01_OFS_CNT1 8'h0C
`define T01_OFS_STAT 8'h10
`define T01_OFS_MASK 8'h14
`define T01_MODE_RST 8'h00
`define T01_CTRL_RST 4'h0
`define T01_FLAG_RST 2'h0
`define T01_CNT_RST 8'h00
`define T01_MD_CT0 2
`define T01_MD_GATE0 3
`define T01_MD_CT1 6
`define T01_MD_GATE1 7
`define T01_CTRL_RUN0 0
`define T01_CTRL_RUN1 1
`define T01_CTRL_CLK0 2
`define T01_CTRL_CLK1 3
`define T01_FLAG0 0
`define T01_FLAG1 1
`define T01_PRESCALE 4'hC
`define T01_LO5_MAX 5'h1F
`endif

// File: hdl/t01_pkg.sv
package t01_pkg;
    typedef enum logic [1:0] {T01_M13, T01_M16, T01_M8R, T01_SPLIT} t01_mode_t;
    typedef enum logic [1:0] {T01_BUS_IDLE, T01_BUS_WR, T01_BUS_RDWAIT, T01_BUS_RDOUT} t01_bus_t;
endpackage : t01_pkg

// File: hdl/t01_byte_cnt.sv
`timescale 1ns/1ps
`default_nettype none
`include "t01_regs.svh"
module t01_byte_cnt
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic inc,
    input wire logic narrow,
    input wire logic reload,
    input wire logic [7:0] reload_val,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] count,
    output logic carry
);
    import t01_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic at_max;
    logic [7:0] stepped;
    logic [7:0] next_count;

    // narrow form keeps the upper three bits and wraps the low five
    assign at_max = narrow ? (count[4:0] == `T01_LO5_MAX) : (count == 8'hFF);
    assign carry = inc && at_max;
    assign stepped = narrow ? {count[7:5], count[4:0] + 5'h01} : count + 8'h01;
    assign next_count = wr_en ? wr_data :
                        !inc ? count :
                        (carry && reload) ? reload_val : stepped;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            count <= `T01_CNT_RST;
        else
            count <= next_count;
    end

    a_reload_value: assert property (
        carry && reload && !wr_en |=> count == $past(reload_val))
        else $error("low byte did not reload from high byte");

    a_byte_step: assert property (
        inc && !at_max && !narrow && !wr_en |=> count == $past(count) + 8'h01)
        else $error("byte counter did not advance by one");
endmodule : t01_byte_cnt
`default_nettype wire

// File: hdl/t01_cnt_qual.sv
`timescale 1ns/1ps
`default_nettype none
module t01_cnt_qual
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic gate_q,
    input wire logic ext_pin,
    input wire logic count_mode,
    input wire logic count_pin,
    input wire logic tick,
    output logic en
);
    import t01_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic pin_prev;
    logic fall;
    logic permit;

    // starts at the pin's rest level, so no false edge right after reset
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pin_prev <= 1'b1;
        else
            pin_prev <= count_pin;
    end

    assign fall = pin_prev && !count_pin;
    assign permit = run && (!gate_q || ext_pin);
    assign en = permit && (count_mode ? fall : tick);

    a_gate_blocks: assert property (
        (gate_q && !ext_pin) || !run |-> !en)
        else $error("count enable despite gate or run closed");

    a_edge_count: assert property (
        en && count_mode |-> $past(count_pin) && !count_pin)
        else $error("counter mode advanced without a falling edge");
endmodule : t01_cnt_qual
`default_nettype wire

// File: hdl/t01_timer.sv
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "t01_regs.svh"
module t01_timer
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic count_input_pin_0,
    input wire logic count_input_pin_1,
    input wire logic ext_gate_pin_0,
    input wire logic ext_gate_pin_1,
    output logic baud_tick,
    output logic irq,
    output var t01_pkg::t01_mode_t t0_mode
);
    import t01_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    t01_bus_t state;
    t01_bus_t next_state;
    logic [7:0] addr_q;
    logic take;
    logic wr_now;
    logic wr_mode;
    logic wr_ctrl;
    logic wr_cnt0;
    logic wr_cnt1;
    logic wr_stat;
    logic wr_mask;
    logic [31:0] rd_data;

    logic [7:0] timer_mode_reg;
    logic [3:0] ctrl_reg;
    logic [1:0] status;
    logic [1:0] next_status;
    logic [1:0] mask;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;

    t01_mode_t m1;
    logic split;
    logic [3:0] pre_cnt;
    logic tick12;
    logic tick0;
    logic tick1;
    logic run_ctl_0;
    logic run_ctl_1;
    logic timer1_clock_select;
    logic en0;
    logic en1q;
    logic en1;

    logic [7:0] count_low_byte_0;
    logic [7:0] count_high_byte_0;
    logic [7:0] lo1;
    logic [7:0] hi1;
    logic lo0_carry;
    logic hi0_carry;
    logic lo1_carry;
    logic hi1_carry;
    logic hi0_inc;
    logic hi1_inc;
    logic t0_ovf;
    logic t1_ovf;

    // bus side: writes finish in their data phase, reads take one wait state
    // so the snapshot of a running counter is stable when the master samples
    assign take = hsel && hready && htrans[1];
    assign hreadyout = (state != T01_BUS_RDWAIT);
    assign hresp = 1'b0;

    always_comb
    begin
        unique case (state)
            T01_BUS_RDWAIT: next_state = T01_BUS_RDOUT;
            T01_BUS_IDLE, T01_BUS_WR, T01_BUS_RDOUT:
                next_state = !take ? T01_BUS_IDLE : hwrite ? T01_BUS_WR : T01_BUS_RDWAIT;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state <= T01_BUS_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            addr_q <= 8'h00;
        else if (take)
            addr_q <= haddr[7:0];
    end

    assign wr_now = (state == T01_BUS_WR);
    assign wr_mode = wr_now && (addr_q == `T01_OFS_MODE);
    assign wr_ctrl = wr_now && (addr_q == `T01_OFS_CTRL);
    assign wr_cnt0 = wr_now && (addr_q == `T01_OFS_CNT0);
    assign wr_cnt1 = wr_now && (addr_q == `T01_OFS_CNT1);
    assign wr_stat = wr_now && (addr_q == `T01_OFS_STAT);
    assign wr_mask = wr_now && (addr_q == `T01_OFS_MASK);

    // unmapped offsets read as zero
    assign rd_data =
        (addr_q == `T01_OFS_MODE) ? {24'h000000, timer_mode_reg} :
        (addr_q == `T01_OFS_CTRL) ? {28'h0000000, ctrl_reg} :
        (addr_q == `T01_OFS_CNT0) ? {16'h0000, count_high_byte_0, count_low_byte_0} :
        (addr_q == `T01_OFS_CNT1) ? {16'h0000, hi1, lo1} :
        (addr_q == `T01_OFS_STAT) ? {30'h00000000, status} :
        (addr_q == `T01_OFS_MASK) ? {30'h00000000, mask} : 32'h00000000;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            hrdata <= 32'h00000000;
        else if (state == T01_BUS_RDWAIT)
            hrdata <= rd_data;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            timer_mode_reg <= `T01_MODE_RST;
        else if (wr_mode)
            timer_mode_reg <= hwdata[7:0];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrl_reg <= `T01_CTRL_RST;
        else if (wr_ctrl)
            ctrl_reg <= hwdata[3:0];
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            mask <= `T01_FLAG_RST;
        else if (wr_mask)
            mask <= hwdata[1:0];
    end

    // flags: write one to clear, a same-cycle overflow wins
    assign flag_clr = wr_stat ? hwdata[1:0] : 2'h0;
    assign next_status = (status & ~flag_clr) | flag_set;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            status <= `T01_FLAG_RST;
        else
            status <= next_status;
    end

    assign irq = |(status & mask);

    // mode decode and clock prescale
    assign t0_mode = t01_mode_t'(timer_mode_reg[1:0]);
    assign m1 = t01_mode_t'(timer_mode_reg[5:4]);
    assign split = (t0_mode == T01_SPLIT);
    assign run_ctl_0 = ctrl_reg[`T01_CTRL_RUN0];
    assign run_ctl_1 = ctrl_reg[`T01_CTRL_RUN1];
    assign timer1_clock_select = ctrl_reg[`T01_CTRL_CLK1];

    assign tick12 = (pre_cnt == `T01_PRESCALE - 4'h1);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pre_cnt <= 4'h0;
        else
            pre_cnt <= tick12 ? 4'h0 : pre_cnt + 4'h1;
    end

    assign tick0 = ctrl_reg[`T01_CTRL_CLK0] || tick12;
    assign tick1 = timer1_clock_select || tick12;

    t01_cnt_qual u_qual0
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(run_ctl_0),
        .gate_q(timer_mode_reg[`T01_MD_GATE0]),
        .ext_pin(ext_gate_pin_0),
        .count_mode(timer_mode_reg[`T01_MD_CT0]),
        .count_pin(count_input_pin_0),
        .tick(tick0),
        .en(en0)
    );

    // with timer 0 split, run bit 1 belongs to the high byte of timer 0
    t01_cnt_qual u_qual1
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(split || run_ctl_1),
        .gate_q(timer_mode_reg[`T01_MD_GATE1]),
        .ext_pin(ext_gate_pin_1),
        .count_mode(timer_mode_reg[`T01_MD_CT1]),
        .count_pin(count_input_pin_1),
        .tick(tick1),
        .en(en1q)
    );

    assign en1 = en1q && (m1 != T01_SPLIT);

    // timer 0
    assign hi0_inc = split ? (run_ctl_1 && tick0) :
                     (t0_mode != T01_M8R) && lo0_carry;

    t01_byte_cnt u_lo0
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .inc(en0),
        .narrow(t0_mode == T01_M13),
        .reload(t0_mode == T01_M8R),
        .reload_val(count_high_byte_0),
        .wr_en(wr_cnt0),
        .wr_data(hwdata[7:0]),
        .count(count_low_byte_0),
        .carry(lo0_carry)
    );

    t01_byte_cnt u_hi0
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .inc(hi0_inc),
        .narrow(1'b0),
        .reload(1'b0),
        .reload_val(8'h00),
        .wr_en(wr_cnt0),
        .wr_data(hwdata[15:8]),
        .count(count_high_byte_0),
        .carry(hi0_carry)
    );

    // timer 1
    assign hi1_inc = (m1 == T01_M13 || m1 == T01_M16) && lo1_carry;

    t01_byte_cnt u_lo1
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .inc(en1),
        .narrow(m1 == T01_M13),
        .reload(m1 == T01_M8R),
        .reload_val(hi1),
        .wr_en(wr_cnt1),
        .wr_data(hwdata[7:0]),
        .count(lo1),
        .carry(lo1_carry)
    );

    t01_byte_cnt u_hi1
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .inc(hi1_inc),
        .narrow(1'b0),
        .reload(1'b0),
        .reload_val(8'h00),
        .wr_en(wr_cnt1),
        .wr_data(hwdata[15:8]),
        .count(hi1),
        .carry(hi1_carry)
    );

    // overflow routing
    assign t0_ovf = split || t0_mode == T01_M8R ? lo0_carry : hi0_carry;
    assign t1_ovf = (m1 == T01_M8R) ? lo1_carry : hi1_carry;
    assign flag_set[`T01_FLAG0] = t0_ovf;
    assign flag_set[`T01_FLAG1] = split ? hi0_carry : t1_ovf;

    // baud source is timer 1 alone, whatever timer 0 is doing
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            baud_tick <= 1'b0;
        else
            baud_tick <= t1_ovf;
    end

    a_t1_frozen: assert property (
        m1 == T01_SPLIT && !wr_cnt1 |=> $stable(lo1) && $stable(hi1))
        else $error("timer 1 advanced in mode 3");

    a_split_high_runs: assert property (
        split && run_ctl_1 && tick0 && !wr_cnt0
        |=> count_high_byte_0 == $past(count_high_byte_0) + 8'h01)
        else $error("split high byte did not count a clock");

    a_split_high_flag: assert property (
        split && hi0_carry |=> status[`T01_FLAG1])
        else $error("split high byte overflow did not set flag 1");

    a_split_low_flag: assert property (
        split && lo0_carry |=> status[`T01_FLAG0])
        else $error("split low byte overflow did not set flag 0");

    a_t1_no_flag: assert property (
        split && t1_ovf && !hi0_carry && !status[`T01_FLAG1] |=> !status[`T01_FLAG1])
        else $error("timer 1 set flag 1 while timer 0 split");

    // a reload from an all-ones high byte leaves the low byte where it was
    a_t1_split_run: assert property (
        split && m1 != T01_SPLIT && !timer_mode_reg[`T01_MD_GATE1]
        && !timer_mode_reg[`T01_MD_CT1] && tick1 && !wr_cnt1
        && !(m1 == T01_M8R && lo1_carry) |=> $changed(lo1))
        else $error("timer 1 did not run while timer 0 split");

    a_baud_source: assert property (
        baud_tick |-> $past(lo1_carry || hi1_carry))
        else $error("baud tick without a timer 1 overflow");

    a_mode2_high_hold: assert property (
        t0_mode == T01_M8R && !wr_cnt0 |=> $stable(count_high_byte_0))
        else $error("reload byte changed in auto-reload mode");
endmodule : t01_timer
`default_nettype wire

// File: dv/t01_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module t01_pins_model
(
    input wire logic clk,
    output logic count_input_pin_0,
    output logic count_input_pin_1,
    output logic ext_gate_pin_0,
    output logic ext_gate_pin_1
);
    // count pins rest high, so only a commanded low is a falling edge
    initial
    begin
        count_input_pin_0 = 1'b1;
        count_input_pin_1 = 1'b1;
        ext_gate_pin_0 = 1'b0;
        ext_gate_pin_1 = 1'b0;
    end

    task automatic set_gates(input logic g0, input logic g1);
        @(posedge clk);
        ext_gate_pin_0 <= g0;
        ext_gate_pin_1 <= g1;
    endtask : set_gates

    // pulses held several cycles so the design's edge sampler sees each one
    task automatic pulses0(input int n);
        @(posedge clk);
        repeat (n)
        begin
            count_input_pin_0 <= 1'b0;
            repeat (3) @(posedge clk);
            count_input_pin_0 <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask : pulses0
endmodule : t01_pins_model
`default_nettype wire

// File: dv/timer01_split_mode_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "t01_regs.svh"
module timer01_split_mode_logic_test;
    import t01_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hreadyout, hresp, baud_tick, irq;
    logic [31:0] hrdata, v;
    logic cp0, cp1, gp0, gp1;
    t01_mode_t t0_mode;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int ticks = 0;
    int b;

    always #2.5 clk = ~clk;
    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    t01_timer i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .count_input_pin_0(cp0), .count_input_pin_1(cp1), .ext_gate_pin_0(gp0),
        .ext_gate_pin_1(gp1), .baud_tick(baud_tick), .irq(irq), .t0_mode(t0_mode));

    t01_pins_model i_pins (.clk(clk), .count_input_pin_0(cp0), .count_input_pin_1(cp1),
        .ext_gate_pin_0(gp0), .ext_gate_pin_1(gp1));

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (baud_tick === 1'b1)
            ticks <= ticks + 1;
        if (cyc == 6000)
        begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        v = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(nm, exp, v & m);
    endtask : rc

    initial
    begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        wr(8'h18, 32'hFFFFFFFF);
        for (int a = 0; a <= 24; a += 4)
            rc("reset reg", 8'(a), 32'hFFFFFFFF, 32'h0);
        chk("t0 mode", {30'h0, T01_M13}, {30'h0, t0_mode});
        chk("hresp", 32'h0, {31'h0, hresp});
        // gate closed by low pin 0, then opened
        wr(`T01_OFS_MODE, 32'h0A);
        wr(`T01_OFS_CNT0, 32'h10);
        wr(`T01_OFS_CTRL, 32'h05);
        repeat (20) @(posedge clk);
        rc("gated cnt0", `T01_OFS_CNT0, 32'hFFFF, 32'h10);
        i_pins.set_gates(1'b1, 1'b0);
        repeat (20) @(posedge clk);
        wr(`T01_OFS_CTRL, 32'h0);
        xfer(`T01_OFS_CNT0, 1'b0, 32'h0);
        // one count per clock from the edge after the pin rose to the stop write
        chk("gate open", 32'h26, {24'h0, v[7:0]});
        chk("gate counted", 32'h0, {24'h0, v[15:8]});
        repeat (10) @(posedge clk);
        rc("stopped cnt0", `T01_OFS_CNT0, 32'hFFFFFFFF, v);
        // auto reload of timer 0
        wr(`T01_OFS_MODE, 32'h02);
        wr(`T01_OFS_MASK, 32'h1);
        wr(`T01_OFS_CNT0, 32'hF0FE);
        b = ticks;
        wr(`T01_OFS_CTRL, 32'h05);
        for (int i = 0; i < 50 && irq !== 1'b1; i++)
            @(posedge clk);
        chk("irq flag0", 32'h1, {31'h0, irq});
        wr(`T01_OFS_CTRL, 32'h0);
        rc("reload", `T01_OFS_CNT0, 32'hFFFFFFF0, 32'hF0F0);
        chk("t0 no baud", 32'(b), 32'(ticks));
        wr(`T01_OFS_STAT, 32'h1);
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // split: high byte on run bit 1, low byte on run bit 0
        wr(`T01_OFS_MODE, 32'h03);
        wr(`T01_OFS_CNT0, 32'hFE00);
        chk("split mode", {30'h0, T01_SPLIT}, {30'h0, t0_mode});
        wr(`T01_OFS_CTRL, 32'h06);
        repeat (20) @(posedge clk);
        wr(`T01_OFS_CTRL, 32'h0);
        rc("split hi flag", `T01_OFS_STAT, 32'hFFFFFFFF, 32'h2);
        chk("irq masked", 32'h0, {31'h0, irq});
        rc("split lo held", `T01_OFS_CNT0, 32'hFF, 32'h0);
        wr(`T01_OFS_STAT, 32'h3);
        wr(`T01_OFS_CNT0, 32'h00F0);
        wr(`T01_OFS_CTRL, 32'h05);
        repeat (30) @(posedge clk);
        wr(`T01_OFS_CTRL, 32'h0);
        rc("split lo flag", `T01_OFS_STAT, 32'hFFFFFFFF, 32'h1);
        rc("split hi held", `T01_OFS_CNT0, 32'hFF00, 32'h0);
        wr(`T01_OFS_STAT, 32'h3);
        wr(`T01_OFS_MODE, 32'h07);
        wr(`T01_OFS_CNT0, 32'h0);
        wr(`T01_OFS_CTRL, 32'h01);
        i_pins.pulses0(5);
        wr(`T01_OFS_CTRL, 32'h0);
        rc("edge count", `T01_OFS_CNT0, 32'hFF, 32'h5);
        // timer 1 beside split timer 0, run bit 1 off
        wr(`T01_OFS_STAT, 32'h3);
        wr(`T01_OFS_MASK, 32'h3);
        wr(`T01_OFS_CTRL, 32'h08);
        for (int m = 0; m < 3; m++)
        begin
            wr(`T01_OFS_MODE, 32'(m * 16 + 3));
            wr(`T01_OFS_CNT1, 32'hFFFE);
            b = ticks;
            repeat (40) @(posedge clk);
            chk("t1 baud", 32'h1, {31'h0, ticks > b});
        end
        rc("no flag1", `T01_OFS_STAT, 32'hFFFFFFFF, 32'h0);
        chk("no t1 irq", 32'h0, {31'h0, irq});
        wr(`T01_OFS_MODE, 32'hA3);
        wr(`T01_OFS_CNT1, 32'hFFFE);
        b = ticks;
        repeat (40) @(posedge clk);
        chk("t1 gated", 32'(b), 32'(ticks));
        i_pins.set_gates(1'b0, 1'b1);
        repeat (40) @(posedge clk);
        chk("t1 pin opens", 32'h1, {31'h0, ticks > b});
        i_pins.set_gates(1'b0, 1'b0);
        wr(`T01_OFS_MODE, 32'h33);
        wr(`T01_OFS_CNT1, 32'h1234);
        b = ticks;
        repeat (40) @(posedge clk);
        rc("t1 off", `T01_OFS_CNT1, 32'hFFFF, 32'h1234);
        chk("t1 off baud", 32'(b), 32'(ticks));
        // mode 3 freezes timer 1 even with its run bit on
        wr(`T01_OFS_MODE, 32'h30);
        wr(`T01_OFS_CTRL, 32'h0A);
        wr(`T01_OFS_CNT1, 32'hFFFE);
        repeat (40) @(posedge clk);
        rc("t1 frozen", `T01_OFS_CNT1, 32'hFFFF, 32'hFFFE);
        wr(`T01_OFS_CTRL, 32'h0);
        results();
    end
endmodule : timer01_split_mode_logic_test
`default_nettype wire
